/* File: wks_pkg.sv */
// Shared constants and types of the wake key sequence detector.
package wks_pkg;
    localparam int          NUM_KEYS  = 12;
    localparam int          MAX_KEYS  = 6;
    localparam int          KEY_W     = 4;
    localparam int          STEP_W    = 3;
    localparam logic [2:0]  LEN_MAX   = 3'h6;
    localparam logic [2:0]  LEN_NONE  = 3'h0;
    localparam logic [2:0]  STEP_ZERO = 3'h0;
    localparam logic [2:0]  STEP_ONE  = 3'h1;
    localparam logic [3:0]  KEY_RST   = 4'h0;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'h1,
        ST_DOZE   = 3'h2,
        ST_WAKE   = 3'h4
    } wks_state_type;
endpackage : wks_pkg

/* File: wks_store_if.sv */
// Connection between the detector and its key sequence store.
`timescale 1ns/1ps
`default_nettype none
interface wks_store_if;
    import wks_pkg::*;
    logic               wr_en;
    logic [STEP_W-1:0]  wr_idx;
    logic [KEY_W-1:0]   wr_key;
    logic [STEP_W-1:0]  rd_idx;
    logic [KEY_W-1:0]   rd_key;
    modport store (input wr_en, input wr_idx, input wr_key, input rd_idx, output rd_key);
    modport user  (output wr_en, output wr_idx, output wr_key, output rd_idx, input rd_key);
endinterface : wks_store_if
`default_nettype wire

/* File: wks_seq_store.sv */
// Small memory holding the ordered key identities of the wake sequence.
`timescale 1ns/1ps
`default_nettype none
module wks_seq_store
    import wks_pkg::*;
(
    input  wire logic   ref_clk,
    input  wire logic   rstn,
    wks_store_if.store  bus
);
    logic [KEY_W-1:0] mem_r [MAX_KEYS];
    logic [KEY_W-1:0] mem_nxt [MAX_KEYS];
    logic [KEY_W-1:0] rd_key_r;
    logic [KEY_W-1:0] rd_key_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < MAX_KEYS; gi++) begin : g_ent
            always_comb begin
                mem_nxt[gi] = mem_r[gi];
                if (bus.wr_en && (int'(bus.wr_idx) == gi)) begin
                    mem_nxt[gi] = bus.wr_key;
                end
            end
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    mem_r[gi] <= KEY_RST;
                end else begin
                    mem_r[gi] <= mem_nxt[gi];
                end
            end
        end
    endgenerate

    // Indices past the last entry read as key zero rather than wrapping.
    always_comb begin
        rd_key_nxt = KEY_RST;
        if (int'(bus.rd_idx) < MAX_KEYS) begin
            rd_key_nxt = mem_r[bus.rd_idx];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rd_key_r <= KEY_RST;
        end else begin
            rd_key_r <= rd_key_nxt;
        end
    end

    assign bus.rd_key = rd_key_r;
endmodule : wks_seq_store
`default_nettype wire

/* File: wks_detector.sv */
// Wake key sequence detector: requests wake from doze on a full, ordered sequence of released keys, or on general input or I2C command.
// Contract
// - Up to six keys form the sequence; a full correct entry requests active mode.
// - Partial sequence progress never requests active mode; device stays in doze.
// - A validated key other than the expected one restarts from the first key.
// - A key counts only after touch then release; a held key does not advance.
// - Sequence disabled: doze is left only on general input or I2C command.
`timescale 1ns/1ps
`default_nettype none
module wks_detector
    import wks_pkg::*;
#(
    parameter int N_KEYS = NUM_KEYS
)(
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic                cfg_wr_key,
    input  wire logic [STEP_W-1:0]   cfg_idx,
    input  wire logic [KEY_W-1:0]    cfg_key,
    input  wire logic                cfg_wr_len,
    input  wire logic [STEP_W-1:0]   cfg_len,
    input  wire logic                seq_enable,
    input  wire logic                doze_mode,
    input  wire logic [N_KEYS-1:0]   key_touched,
    input  wire logic                general_input_pin,
    input  wire logic                i2c_wake_cmd,
    output logic                     wake_request,
    output logic [STEP_W-1:0]        seq_step
);
    wks_store_if sif ();

    wks_seq_store u_store (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .bus     (sif.store)
    );

    wks_state_type      state_r;
    wks_state_type      state_nxt;
    logic [STEP_W-1:0]  step_r;
    logic [STEP_W-1:0]  step_nxt;
    logic [STEP_W-1:0]  len_r;
    logic [STEP_W-1:0]  len_nxt;
    logic [N_KEYS-1:0]  touched_r;
    logic               wake_req_r;
    logic               wake_req_nxt;
    logic [N_KEYS-1:0]  released;
    logic [N_KEYS-1:0]  expect_vec;
    logic               seq_on;
    logic               advance;
    logic               wrong;
    logic               seq_done;
    logic               other_wake;

    // A release is a key seen touched last cycle and untouched now.
    assign released   = touched_r & ~key_touched;
    assign expect_vec = (int'(sif.rd_key) < N_KEYS) ? (N_KEYS'(1) << sif.rd_key) : '0;
    assign seq_on     = seq_enable && (len_r != LEN_NONE);
    // Two keys released in the same cycle cannot be ordered, so they count as a wrong entry.
    assign advance    = seq_on && (released == expect_vec) && (released != '0);
    assign wrong      = seq_on && (released != '0) && !advance;
    assign seq_done   = advance && (step_r == (len_r - STEP_ONE));
    assign other_wake = general_input_pin || i2c_wake_cmd;

    assign sif.wr_en  = cfg_wr_key;
    assign sif.wr_idx = cfg_idx;
    assign sif.wr_key = cfg_key;
    // Reading at the next step keeps the expected key ready one cycle ahead.
    assign sif.rd_idx = step_nxt;

    always_comb begin
        len_nxt = len_r;
        if (cfg_wr_len) begin
            len_nxt = (cfg_len > LEN_MAX) ? LEN_MAX : cfg_len;
        end
    end

    always_comb begin
        state_nxt    = state_r;
        step_nxt     = step_r;
        wake_req_nxt = wake_req_r;
        case (state_r)
            ST_ACTIVE: begin
                step_nxt     = STEP_ZERO;
                wake_req_nxt = 1'b0;
                if (doze_mode) begin
                    state_nxt = ST_DOZE;
                end
            end
            ST_DOZE: begin
                if (!doze_mode) begin
                    state_nxt = ST_ACTIVE;
                    step_nxt  = STEP_ZERO;
                end else if (seq_done || other_wake) begin
                    state_nxt    = ST_WAKE;
                    wake_req_nxt = 1'b1;
                    step_nxt     = STEP_ZERO;
                end else if (wrong) begin
                    step_nxt = STEP_ZERO;
                end else if (advance) begin
                    step_nxt = step_r + STEP_ONE;
                end
            end
            ST_WAKE: begin
                // The request stands until the power manager has left doze.
                step_nxt = STEP_ZERO;
                if (!doze_mode) begin
                    state_nxt    = ST_ACTIVE;
                    wake_req_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt    = ST_ACTIVE;
                step_nxt     = STEP_ZERO;
                wake_req_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r    <= ST_ACTIVE;
            step_r     <= STEP_ZERO;
            len_r      <= LEN_NONE;
            touched_r  <= '0;
            wake_req_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            step_r     <= step_nxt;
            len_r      <= len_nxt;
            touched_r  <= key_touched;
            wake_req_r <= wake_req_nxt;
        end
    end

    assign wake_request = wake_req_r;
    assign seq_step     = step_r;

    sequence s_doze_held;
        state_r == ST_DOZE && doze_mode;
    endsequence

    sequence s_final_key;
        s_doze_held ##0 seq_done && !other_wake;
    endsequence

    property p_step_bound;
        @(posedge ref_clk) disable iff (!rstn)
            (state_r == ST_DOZE) |-> (step_r < len_r || step_r == STEP_ZERO) && len_r <= LEN_MAX;
    endproperty
    a_step_bound: assert property (p_step_bound) else $error("sequence step beyond configured length");

    property p_full_wakes;
        @(posedge ref_clk) disable iff (!rstn)
            s_final_key |=> wake_request && state_r == ST_WAKE;
    endproperty
    a_full_wakes: assert property (p_full_wakes) else $error("complete sequence did not request wake");

    property p_no_partial;
        @(posedge ref_clk) disable iff (!rstn)
            $rose(wake_request) |-> $past(seq_done) || $past(other_wake);
    endproperty
    a_no_partial: assert property (p_no_partial) else $error("wake requested without full sequence");

    property p_wrong_restart;
        @(posedge ref_clk) disable iff (!rstn)
            s_doze_held ##0 (wrong && !other_wake) |=> step_r == STEP_ZERO && !wake_request;
    endproperty
    a_wrong_restart: assert property (p_wrong_restart) else $error("wrong key did not restart sequence");

    property p_held_key;
        @(posedge ref_clk) disable iff (!rstn)
            s_doze_held ##0 (released == '0 && !other_wake) |=> step_r == $past(step_r);
    endproperty
    a_held_key: assert property (p_held_key) else $error("step moved without a key release");

    property p_disabled_only_other;
        @(posedge ref_clk) disable iff (!rstn)
            s_doze_held ##0 (!seq_enable && !other_wake) |=> !wake_request && (step_r == $past(step_r));
    endproperty
    a_disabled_only_other: assert property (p_disabled_only_other) else $error("sensor woke with sequence disabled");

    property p_other_wakes;
        @(posedge ref_clk) disable iff (!rstn)
            s_doze_held ##0 other_wake |=> wake_request;
    endproperty
    a_other_wakes: assert property (p_other_wakes) else $error("general input or command did not wake");

    property p_reset_after_wake;
        @(posedge ref_clk) disable iff (!rstn)
            wake_request |-> step_r == STEP_ZERO ##1 (!wake_request || step_r == STEP_ZERO);
    endproperty
    a_reset_after_wake: assert property (p_reset_after_wake) else $error("progress not cleared after wake");

    // The request is a level: dropping it early would let the power manager miss the wake.
    property p_wake_holds;
        @(posedge ref_clk) disable iff (!rstn)
            wake_request && doze_mode |=> wake_request;
    endproperty
    a_wake_holds: assert property (p_wake_holds) else $error("wake request dropped while still in doze");

    property p_active_quiet;
        @(posedge ref_clk) disable iff (!rstn)
            (state_r == ST_ACTIVE) |=> !wake_request && step_r == STEP_ZERO;
    endproperty
    a_active_quiet: assert property (p_active_quiet) else $error("progress or request outside doze");

    property p_advance_step;
        @(posedge ref_clk) disable iff (!rstn)
            s_doze_held ##0 (advance && !seq_done && !other_wake) |=> step_r == $past(step_r) + STEP_ONE && !wake_request;
    endproperty
    a_advance_step: assert property (p_advance_step) else $error("partial entry did not step once without wake");

    property p_still_keys;
        @(posedge ref_clk) disable iff (!rstn)
            s_doze_held ##0 (key_touched == $past(key_touched) && !other_wake) |=> step_r == $past(step_r);
    endproperty
    a_still_keys: assert property (p_still_keys) else $error("step moved while no key changed");
endmodule : wks_detector
`default_nettype wire

/* File: wks_detector_end.sv */
// Empty unit kept beside the detector; it holds no logic of its own.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: wks_key_model.sv */
// Behavioural model of the button detection logic that reports key touch and release.
`timescale 1ns/1ps
`default_nettype none
module wks_key_model
    import wks_pkg::*;
(
    input  wire logic                  ref_clk,
    output var  logic [NUM_KEYS-1:0]   key_touched
);
    initial begin
        key_touched = '0;
    end

    // Every touch ends in a release; no key is held on like a proximity pad, which would block the sequence.
    task automatic set_key(input int k, input logic v);
        @(posedge ref_clk);
        key_touched[k] <= v;
    endtask : set_key

    task automatic tap(input int k, input int hold);
        set_key(k, 1'b1);
        repeat (hold) @(posedge ref_clk);
        set_key(k, 1'b0);
        repeat (3) @(posedge ref_clk);
    endtask : tap

    // Two keys touched and released together cannot be ordered by the detector.
    task automatic tap_pair(input int a, input int b);
        @(posedge ref_clk);
        key_touched[a] <= 1'b1;
        key_touched[b] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        key_touched[a] <= 1'b0;
        key_touched[b] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : tap_pair
endmodule : wks_key_model
`default_nettype wire

/* File: wks_detector_tb_top.sv */
// Self-checking testbench of the wake key sequence detector.
`timescale 1ns/1ps
`default_nettype none
module wks_detector_tb_top;
    import wks_pkg::*;
    logic                  ref_clk, rstn, cfg_wr_key, cfg_wr_len, seq_enable, doze_mode;
    logic                  general_input_pin, i2c_wake_cmd, wake_request;
    logic [STEP_W-1:0]     cfg_idx, cfg_len, seq_step;
    logic [KEY_W-1:0]      cfg_key;
    logic [NUM_KEYS-1:0]   key_touched;
    int                    err_count, checks_done;
    int                    seq_keys [6] = '{3, 5, 7, 11, 0, 9};

    wks_detector #(.N_KEYS(NUM_KEYS)) wks_detector_i (.ref_clk(ref_clk), .rstn(rstn),
        .cfg_wr_key(cfg_wr_key), .cfg_idx(cfg_idx), .cfg_key(cfg_key), .cfg_wr_len(cfg_wr_len),
        .cfg_len(cfg_len), .seq_enable(seq_enable), .doze_mode(doze_mode), .key_touched(key_touched),
        .general_input_pin(general_input_pin), .i2c_wake_cmd(i2c_wake_cmd),
        .wake_request(wake_request), .seq_step(seq_step));
    wks_key_model wks_key_model_i (.ref_clk(ref_clk), .key_touched(key_touched));

    always #12.5 ref_clk = ~ref_clk;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk1

    task automatic chk3(input string what, input logic [2:0] exp, input logic [2:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk3

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic set_doze(input logic v);
        @(posedge ref_clk);
        doze_mode <= v;
        tick(3);
        if (!v) chk1("wake_request after doze", 1'b0, wake_request);
    endtask : set_doze

    task automatic pulse_wake(input logic gpin);
        @(posedge ref_clk);
        general_input_pin <= gpin;
        i2c_wake_cmd      <= !gpin;
        @(posedge ref_clk);
        general_input_pin <= 1'b0;
        i2c_wake_cmd      <= 1'b0;
        tick(2);
        chk1("wake_request by event", 1'b1, wake_request);
    endtask : pulse_wake

    // A length above the maximum is written on purpose; it must clamp to six keys.
    task automatic config_seq();
        @(posedge ref_clk);
        cfg_wr_len <= 1'b1;
        cfg_len    <= 3'h7;
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            cfg_wr_len <= 1'b0;
            cfg_wr_key <= 1'b1;
            cfg_idx    <= i[2:0];
            cfg_key    <= seq_keys[i][3:0];
        end
        @(posedge ref_clk);
        cfg_wr_key <= 1'b0;
    endtask : config_seq

    task automatic test_full();
        set_doze(1'b1);
        for (int i = 0; i < 5; i++) begin
            wks_key_model_i.tap(seq_keys[i], 2);
            chk3("seq_step", 3'(i + 1), seq_step);
            chk1("wake_request partial", 1'b0, wake_request);
        end
        wks_key_model_i.tap(seq_keys[5], 1);
        chk1("wake_request full", 1'b1, wake_request);
        chk3("seq_step after wake", STEP_ZERO, seq_step);
        tick(4);
        chk1("wake_request stands", 1'b1, wake_request);
        set_doze(1'b0);
        $display("test full done");
    endtask : test_full

    task automatic test_held();
        set_doze(1'b1);
        wks_key_model_i.set_key(seq_keys[0], 1'b1);
        tick(6);
        chk3("seq_step held", STEP_ZERO, seq_step);
        wks_key_model_i.set_key(seq_keys[0], 1'b0);
        tick(3);
        chk3("seq_step released", STEP_ONE, seq_step);
        set_doze(1'b0);
        $display("test held done");
    endtask : test_held

    task automatic test_wrong();
        set_doze(1'b1);
        wks_key_model_i.tap(seq_keys[0], 1);
        wks_key_model_i.tap(seq_keys[1], 1);
        chk3("seq_step two", 3'h2, seq_step);
        wks_key_model_i.tap(seq_keys[0], 1);
        chk3("seq_step wrong", STEP_ZERO, seq_step);
        wks_key_model_i.tap(seq_keys[0], 1);
        chk3("seq_step restart", STEP_ONE, seq_step);
        set_doze(1'b0);
        $display("test wrong done");
    endtask : test_wrong

    task automatic test_disabled();
        @(posedge ref_clk);
        seq_enable <= 1'b0;
        set_doze(1'b1);
        for (int i = 0; i < 6; i++) wks_key_model_i.tap(seq_keys[i], 1);
        chk1("wake_request disabled", 1'b0, wake_request);
        chk3("seq_step disabled", STEP_ZERO, seq_step);
        pulse_wake(1'b1);
        set_doze(1'b0);
        set_doze(1'b1);
        pulse_wake(1'b0);
        set_doze(1'b0);
        seq_enable <= 1'b1;
        $display("test disabled done");
    endtask : test_disabled

    // A reset in mid-sequence must drop progress and the loaded length alike.
    task automatic test_reset();
        set_doze(1'b1);
        wks_key_model_i.tap(seq_keys[0], 1);
        chk3("seq_step before reset", STEP_ONE, seq_step);
        @(posedge ref_clk);
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        tick(2);
        chk1("wake_request mid reset", 1'b0, wake_request);
        chk3("seq_step mid reset", STEP_ZERO, seq_step);
        for (int i = 0; i < 6; i++) wks_key_model_i.tap(seq_keys[i], 1);
        chk1("wake_request no length", 1'b0, wake_request);
        chk3("seq_step no length", STEP_ZERO, seq_step);
        set_doze(1'b0);
        config_seq();
        $display("test reset done");
    endtask : test_reset

    task automatic test_pair();
        set_doze(1'b1);
        for (int i = 0; i < 5; i++) wks_key_model_i.tap(seq_keys[i], 1);
        chk3("seq_step five", 3'h5, seq_step);
        chk1("wake_request five", 1'b0, wake_request);
        wks_key_model_i.tap_pair(seq_keys[5], seq_keys[0]);
        chk3("seq_step pair", STEP_ZERO, seq_step);
        chk1("wake_request pair", 1'b0, wake_request);
        for (int i = 0; i < 6; i++) wks_key_model_i.tap(seq_keys[i], 1);
        chk1("wake_request after restart", 1'b1, wake_request);
        set_doze(1'b0);
        $display("test pair done");
    endtask : test_pair

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end

    initial begin
        {ref_clk, rstn, cfg_wr_key, cfg_wr_len, doze_mode, general_input_pin, i2c_wake_cmd} = '0;
        {cfg_idx, cfg_len, cfg_key} = '0;
        seq_enable = 1'b1;
        tick(10);
        rstn <= 1'b1;
        tick(2);
        chk1("wake_request reset", 1'b0, wake_request);
        chk3("seq_step reset", STEP_ZERO, seq_step);
        config_seq();
        test_full();
        test_held();
        test_wrong();
        test_disabled();
        test_reset();
        test_pair();
        complete_run();
    end
endmodule : wks_detector_tb_top
`default_nettype wire
